// *** design/dsl_regs.vh ***
// Purpose: Shared constants of the serial channel loader
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef DSL_REGS_VH
`define DSL_REGS_VH
`define DSL_ADDR_W      5
`define DSL_CODE_W      14
`define DSL_FRAME_BITS  19
`define DSL_CHANNELS    32
`define DSL_CODE_RST    14'h0000
`define DSL_CODE_MAX    14'h3FFF
`define DSL_CODE_LSB    0
`define DSL_ADDR_LSB    14
`define DSL_GAP_NS      200
`define DSL_SCLK_MAX_MHZ 30
`define DSL_CLK_MHZ     50
`endif

// *** design/dsl_pin_sync.v ***
// Purpose: Three-stage synchroniser with edge detection for a pin
// Assumes: Pin is asynchronous to ref_clk
// Notes:   Stage one feeds stage two only; edges use stages two and three
`default_nettype none
module dsl_pin_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire ref_clk,   // System clock
    input  wire rst,       // Asynchronous reset, active high
    input  wire pin,       // Raw pin level
    output wire level,     // Agreed level
    output wire rise,      // One-cycle pulse on agreed rise
    output wire fall       // One-cycle pulse on agreed fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg lvl_q;

    // Shift chain and agreed level
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    // Change counts once stages two and three agree
    assign level = lvl_q;
    assign rise  = (s2_q == s3_q) && s3_q && !lvl_q;
    assign fall  = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule // dsl_pin_sync
`default_nettype wire

// *** design/dsl_loader.v ***
// Purpose: Serial front end loading 14-bit codes into 32 channel registers
// Assumes: Link pins sampled by ref_clk at 50 MHz; sclk at most 12.5 MHz
// Notes:   All 32 codes leave as one flat bus, channel n at bits n*14
//          Pins pass a three-stage sync, so updates trail the pins by
//          about four clocks; sclk high and low each need two clocks
// How it works
// RQ1 - Each frame yields a 5-bit address and 14-bit code for one channel
// RQ2 - All channel registers start at zero after power-up
// RQ3 - Codes are unsigned straight binary, 0 to 16383
// RQ4 - Reset pin low clears every register and all channel codes
// RQ5 - Data input is sampled at each falling serial clock edge
// RQ6 - Host sends exactly 19 bits per channel update
// RQ7 - Address selects one of 32 channels, top bit most significant
// RQ8 - Works with continuous or gated serial clock
// RQ9 - First falling frame sync edge clears the bit counter
// RQ10 - Frame sync changes ignored until all 19 bits are in
// RQ11 - After 19 bits further serial clock edges are ignored until rearmed
// RQ12 - Host gives a new frame sync falling edge before each transfer
// RQ13 - Host leaves at least 200 ns between frames
// RQ14 - Host serial clock stays at or below 30 MHz; the loader takes sclk only up to 12.5 MHz
// RQ15 - Frame sync active low; shift one bit per falling clock while low
// RQ16 - Host sends address then code, most significant bit first
// RQ17 - Broadcast pin high writes the received code to all channels
// RQ18 - Update on the 19th bit; aborted frames change nothing; code keeps the count and the next frame completes it
`default_nettype none
`include "dsl_regs.vh"
module dsl_loader #(
    parameter ADDR_W   = `DSL_ADDR_W,
    parameter CODE_W   = `DSL_CODE_W,
    parameter CHANNELS = `DSL_CHANNELS
) (
    input  wire                       ref_clk,     // System clock 50 MHz
    input  wire                       rst,         // Async reset, high
    input  wire                       reset_n,     // Device reset pin, low
    input  wire                       sclk,        // Serial clock pin
    input  wire                       sdata,       // Serial data pin
    input  wire                       fsync_n,     // Frame sync, low
    input  wire                       bcast,       // Broadcast load pin
    output reg  [CHANNELS*CODE_W-1:0] chan_codes,  // All channel codes
    output reg                        load_pulse,  // One cycle per update
    output reg                        busy         // Frame in progress
);
    localparam FRAME_W = ADDR_W + CODE_W;
    localparam CNT_W   = 5;
    // Count of the final bit, cut to the counter's width on purpose
    localparam integer     LAST_I   = `DSL_FRAME_BITS - 1;
    localparam [CNT_W-1:0] LAST_BIT = LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};
    // One-hot frame states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    wire sclk_fall;
    wire fs_fall;
    wire fs_lvl;
    wire rstpin_lvl;
    wire bcast_lvl;
    wire dat_lvl;
    wire clr;
    wire bit_stb;

    // Sequencer state and its next values
    reg [2:0]         state_q;
    reg [2:0]         state_d;
    reg [CNT_W-1:0]   cnt_q;
    reg [CNT_W-1:0]   cnt_d;
    reg [FRAME_W-2:0] shreg_q;
    reg [FRAME_W-2:0] shreg_d;
    reg               busy_d;
    reg               load_d;

    // True when the count stands on the final bit of a frame
    function is_last;
        input [CNT_W-1:0] cnt;
        begin
            is_last = (cnt == LAST_BIT);
        end
    endfunction

    // True when channel idx takes the code of the current frame
    function hits_chan;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] idx;
        input              all;
        begin
            hits_chan = all || (addr == idx);
        end
    endfunction

    dsl_pin_sync #(.RST_VAL(1'b1)) u_sclk (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (sclk),
        .level   (),
        .rise    (),
        .fall    (sclk_fall)
    );
    dsl_pin_sync #(.RST_VAL(1'b1)) u_fs (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (fsync_n),
        .level   (fs_lvl),
        .rise    (),
        .fall    (fs_fall)
    );
    dsl_pin_sync #(.RST_VAL(1'b1)) u_rstpin (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (reset_n),
        .level   (rstpin_lvl),
        .rise    (),
        .fall    ()
    );
    dsl_pin_sync #(.RST_VAL(1'b0)) u_bcast (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (bcast),
        .level   (bcast_lvl),
        .rise    (),
        .fall    ()
    );
    dsl_pin_sync #(.RST_VAL(1'b1)) u_dat (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (sdata),
        .level   (dat_lvl),
        .rise    (),
        .fall    ()
    );

    // Reset pin held low acts as a synchronous clear of everything
    assign clr = !rstpin_lvl; // RQ4

    // A bit counts on a falling link clock while the frame is selected
    assign bit_stb = sclk_fall && !fs_lvl; // RQ5 RQ15 RQ8

    // Next state of the sequencer; frame sync edges ignored mid-frame
    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shreg_d = shreg_q;
        busy_d  = busy;
        load_d  = 1'b0;
        case (state_q)
            ST_IDLE, ST_DONE: begin
                // Only a falling frame sync arms a new count
                if (fs_fall) begin
                    state_d = ST_SHIFT; // RQ9
                    cnt_d   = {CNT_W{1'b0}}; // RQ9
                    busy_d  = 1'b1;
                end
            end
            ST_SHIFT: begin
                // Stays armed through an aborted frame until bit 19
                if (bit_stb) begin // RQ10
                    if (is_last(cnt_q)) begin
                        state_d = ST_DONE; // RQ11
                        busy_d  = 1'b0;
                        load_d  = 1'b1; // RQ18
                    end else begin
                        shreg_d = {shreg_q[FRAME_W-3:0], dat_lvl};
                        cnt_d   = cnt_q + CNT_ONE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // Sequencer registers; the reset pin clears them like the reset input
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            cnt_q      <= {CNT_W{1'b0}};
            shreg_q    <= {(FRAME_W-1){1'b0}};
            busy       <= 1'b0;
            load_pulse <= 1'b0;
        end else if (clr) begin
            state_q    <= ST_IDLE; // RQ4
            cnt_q      <= {CNT_W{1'b0}};
            shreg_q    <= {(FRAME_W-1){1'b0}};
            busy       <= 1'b0;
            load_pulse <= 1'b0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shreg_q    <= shreg_d;
            busy       <= busy_d;
            load_pulse <= load_d;
        end
    end

    // Channel registers: the 19th bit completes the frame in place
    wire [FRAME_W-1:0] frame_w = {shreg_q, dat_lvl};
    wire [ADDR_W-1:0]  addr_w  = frame_w[FRAME_W-1:`DSL_ADDR_LSB]; // RQ7
    wire [CODE_W-1:0]  code_w  = frame_w[CODE_W-1:`DSL_CODE_LSB]; // RQ3
    integer i;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chan_codes <= {CHANNELS{`DSL_CODE_RST}}; // RQ2
        end else if (clr) begin
            chan_codes <= {CHANNELS{`DSL_CODE_RST}}; // RQ4
        end else if (load_d) begin // RQ18
            // Broadcast or the decoded address picks the channels
            for (i = 0; i < CHANNELS; i = i + 1) begin
                if (hits_chan(addr_w, i[ADDR_W-1:0], bcast_lvl)) begin // RQ17
                    chan_codes[i*CODE_W +: CODE_W] <= code_w; // RQ1
                end
            end
        end
    end
endmodule // dsl_loader
`default_nettype wire

// *** test/dsl_host.sv ***
// Purpose: Host serial master that sends frames into the loader
// Assumes: Link clock period 160 ns, parked high outside frames unless free is set
// Notes:   Released data is driven high by the model
`default_nettype none
module dsl_host (
    output wire logic sclk,           // Link clock
    output var  logic sdata = 1'b1,   // Serial data
    output var  logic fsync_n = 1'b1, // Frame sync
    input  wire logic free            // Keep clock running
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ck = 1'b1;
    logic run = 1'b0;
    // Link clock at 6.25 MHz, gated unless free
    always #80 ck = ~ck;
    assign sclk = (run | free) ? ck : 1'b1;
    // Sends the top n bits of w, data set on the rise before each fall
    task automatic frame(input logic [18:0] w, input int n, input bit k);
        for (int i = 18; i > 18 - n; i--) begin
            @(posedge ck);
            // A short high pulse mid-frame when k asks for a sync glitch
            fsync_n = (k && i == 9);
            sdata = w[i];
            run = 1'b1;
            if (k && i == 9) begin
                #60 fsync_n = 1'b0;
            end
        end
        @(posedge ck);
        run = 1'b0;
        sdata = 1'b1;
        fsync_n = 1'b1;
        #240;
    endtask
endmodule // dsl_host
`default_nettype wire

// *** test/dsl_loader_checker.sv ***
// Purpose: Port assertions for the loader
// Assumes: Pins reach the core through a short sync
// Notes:   Bound to every loader instance
`default_nettype none
module dsl_chk #(parameter CODE_W = 14, parameter CHANNELS = 32) (
    input wire logic                       ref_clk,    // Clock
    input wire logic                       rst,        // Reset
    input wire logic                       reset_n,    // Pin reset
    input wire logic                       fsync_n,    // Sync
    input wire logic                       bcast,      // Load all
    input wire logic [CHANNELS*CODE_W-1:0] chan_codes, // Codes
    input wire logic                       load_pulse, // Update
    input wire logic                       busy        // In frame
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Updates, framing and clears
    a_only_load: assert property ($changed(chan_codes) |->
        load_pulse || $past(load_pulse) || chan_codes == '0)
        else $error("code changed without update");
    a_pulse_one: assert property (load_pulse |=> !load_pulse)
        else $error("update pulse too long");
    a_end_loads: assert property ($fell(busy) && reset_n |->
        ##[0:3] load_pulse) else $error("frame end without update");
    a_pin_clear: assert property (!reset_n [*6] |->
        chan_codes == '0 && !busy) else $error("pin reset not clearing");
    a_rst_zero: assert property ($fell(rst) |->
        chan_codes == '0 && !busy && !load_pulse) else $error("bad start");
    a_sync_arms: assert property ($fell(fsync_n) && !busy && reset_n |->
        ##[1:8] busy) else $error("frame not armed");
    a_idle_quiet: assert property ((!busy && fsync_n) [*8] |=>
        !load_pulse) else $error("update while idle");
    a_bcast_all: assert property (load_pulse && bcast && $past(bcast, 8) |->
        chan_codes == {CHANNELS{chan_codes[CODE_W-1:0]}})
        else $error("broadcast missed channels");
    c_load: cover property (load_pulse);
    c_bcast: cover property (load_pulse && bcast);
    c_pin: cover property (!reset_n && chan_codes == '0);
endmodule // dsl_chk
bind dsl_loader dsl_chk #(.CODE_W(CODE_W), .CHANNELS(CHANNELS)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .reset_n(reset_n), .fsync_n(fsync_n),
    .bcast(bcast), .chan_codes(chan_codes), .load_pulse(load_pulse),
    .busy(busy));
`default_nettype wire

// *** test/dsl_loader_test.sv ***
// Purpose: Self-checking bench for the loader
// Assumes: 50 MHz clock, host model makes the link clock
// Notes:   exp holds the code each channel should show
`default_nettype none
module dsl_loader_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic         reset_n = 1'b1;
    logic         bcast = 1'b0;
    logic         free = 1'b0;
    wire          sclk, sdata, fsync_n, load_pulse, busy;
    wire  [447:0] codes;
    logic [13:0]  exp [32] = '{default: 14'h0000};
    int           mismatches = 0;
    int           n_checks = 0;
    int           n_loads = 0;
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // Counts update pulses as the design raises them
    always @(posedge ref_clk) begin
        if (load_pulse === 1'b1)
            n_loads <= n_loads + 1;
    end
    dsl_host host (.sclk(sclk), .sdata(sdata), .fsync_n(fsync_n), .free(free));
    dsl_loader dut (.ref_clk(ref_clk), .rst(rst), .reset_n(reset_n),
        .sclk(sclk), .sdata(sdata), .fsync_n(fsync_n), .bcast(bcast),
        .chan_codes(codes), .load_pulse(load_pulse), .busy(busy));
    task automatic report_and_stop;
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // Compares every channel with the table
    task automatic cmp_all;
        tick(1);
        for (int i = 0; i < 32; i++) begin
            n_checks++;
            if (codes[i*14 +: 14] !== exp[i]) begin
                mismatches++;
                $display("[ERR] %0t got %h exp %h", $time, codes[i*14 +: 14],
                         exp[i]);
            end
        end
    endtask
    // Compares a count or level with its expected value
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    // Sends one full frame and tracks the table
    task automatic wr(input logic [4:0] a, input logic [13:0] c, input bit k);
        host.frame({a, c}, 19, k);
        if (bcast)
            exp = '{default: c};
        else
            exp[a] = c;
    endtask
    task automatic t_all;
        int l0;
        cmp_all();
        l0 = n_loads;
        for (int i = 0; i < 32; i++)
            wr(i[4:0], (i == 31) ? 14'h3FFF : 14'(i * 'h211), 0);
        cmp_all();
        cmp_val(n_loads - l0, 32);
    endtask
    // Abort, then the next frame finishes the old count
    task automatic t_abort;
        logic [18:0] w1 = {5'h05, 14'h1555};
        logic [18:0] w2 = {5'h0A, 14'h2AAA};
        logic [18:0] m = {w1[18:9], w2[18:10]};
        int l0;
        l0 = n_loads;
        host.frame(w1, 10, 0);
        cmp_all();
        cmp_val(busy, 1);
        cmp_val(n_loads - l0, 0);
        host.frame(w2, 19, 0);
        exp[m[18:14]] = m[13:0];
        cmp_all();
        cmp_val(n_loads - l0, 1);
        cmp_val(busy, 0);
        wr(5'h07, 14'h0F0F, 1);
        cmp_all();
    endtask
    task automatic t_bcast;
        tick(1);
        bcast = 1'b1;
        wr(5'h00, 14'h2B3C, 0);
        cmp_all();
        bcast = 1'b0;
    endtask
    task automatic t_pin;
        reset_n = 1'b0;
        tick(8);
        exp = '{default: 14'h0000};
        cmp_all();
        reset_n = 1'b1;
        tick(8);
    endtask
    task automatic t_free;
        free = 1'b1;
        wr(5'h1F, 14'h3FFF, 0);
        wr(5'h10, 14'h2001, 0);
        cmp_all();
        free = 1'b0;
    endtask
    initial begin
        tick(6);
        rst = 1'b0;
        tick(4);
        t_all();
        t_abort();
        t_bcast();
        t_pin();
        t_free();
        report_and_stop();
    end
    // Watchdog, about eight times the expected run
    initial begin
        #1000000;
        mismatches++;
        report_and_stop();
    end
endmodule // dsl_loader_test
`default_nettype wire
